// ===== hdl/timer_evt_pkg.sv
// constants for the timer event, capture and interrupt-flag block
package timer_evt_pkg;
	localparam int ADDR_W = 4;
	localparam int DATA_W = 8;
	localparam int COUNT_W = 16;

	localparam logic [3:0] OFS_EVENT_INPUT = 4'h4;
	localparam logic [3:0] OFS_IRQ_ENABLE  = 4'h5;
	localparam logic [3:0] OFS_IRQ_FLAG    = 4'h6;
	localparam logic [3:0] OFS_RUN_STATE   = 4'h7;
	localparam logic [3:0] OFS_DEBUG_HALT  = 4'h8;
	localparam logic [3:0] OFS_WIDE_LATCH  = 4'h9;
	localparam logic [3:0] OFS_COUNT_LO    = 4'ha;
	localparam logic [3:0] OFS_COUNT_HI    = 4'hb;
	localparam logic [3:0] OFS_SNAP_LO     = 4'hc;
	localparam logic [3:0] OFS_SNAP_HI     = 4'hd;

	localparam int BIT_EVENT_ENABLE = 0;
	localparam int BIT_EDGE         = 4;
	localparam int BIT_FILTER       = 6;
	localparam int BIT_SNAP_FLAG    = 0;
	localparam int BIT_RUN          = 0;
	localparam int BIT_BYPASS       = 0;

	localparam logic [7:0] RST_BYTE  = 8'h00;
	localparam logic [7:0] EVT_MASK  = 8'h51;
	localparam logic [7:0] BIT0_MASK = 8'h01;

	typedef enum logic [2:0] {
		MODE_PERIODIC  = 3'h0,
		MODE_TIMEOUT   = 3'h1,
		MODE_CAPTURE   = 3'h2,
		MODE_FREQ      = 3'h3,
		MODE_PULSE     = 3'h4,
		MODE_FREQPULSE = 3'h5,
		MODE_SINGLE    = 3'h6,
		MODE_PWM8      = 3'h7
	} timer_mode_t;

	typedef enum logic [2:0] {
		FP_IDLE = 3'b001,
		FP_MEAS = 3'b010,
		FP_WAIT = 3'b100
	} fp_state_t;
endpackage

// ===== hdl/edge_detect.sv
// rising and falling edge pulses of a synchronous level
`timescale 1ns/100ps
`default_nettype none
module edge_detect (
	input  wire logic mclk,     // peripheral clock
	input  wire logic rst_b,    // async reset, active low
	input  wire logic level,    // sampled level
	output logic      rise,     // one-cycle pulse on 0->1
	output logic      fall      // one-cycle pulse on 1->0
);
	logic prev_r;

	always_ff @(posedge mclk or negedge rst_b) begin
		if (!rst_b)
			prev_r <= 1'b0;
		else
			prev_r <= level;
	end

	assign rise = level & ~prev_r;
	assign fall = ~level & prev_r;
endmodule
`default_nettype wire

// ===== hdl/timer_event_capture_ctrl.sv
// event edge handling, capture flag, run status, debug halt and 16-bit access latch
`timescale 1ns/100ps
`default_nettype none
// Functional notes
// - time-out mode: polarity picks start/stop edges; single-shot starts on rising or either edge
// - periodic and 8-bit PWM modes ignore all events
// - capture mode: selected edge copies counter and sets flag, counting continues
// - frequency mode: selected edge captures, clears and restarts counter, sets flag
// - pulse-width mode: one edge clears/restarts, the other captures and sets flag
// - combined mode: first edge restarts, next opposite captures, second edge stops and flags
// - periodic, time-out, single-shot: flag set when counter equals 16-bit top
// - 8-bit PWM: flag set when counter equals low byte of compare value
// - captures keep counting, except frequency mode which restarts from bottom
// - events act only while event enable bit 0 is one
// - interrupt raised while flag set and interrupt enable bit 0 is one
// - flag clears on write one, or on capture register read in capture modes
// - run bit reads one while counting; read only
// - bypass bit zero halts block and ignores events during break debug
// - one shared 8-bit latch, readable and writable, serves all 16-bit registers
// - mode codes 0..7: periodic, timeout, capture, freq, pulse, both, single, pwm8
module timer_event_capture_ctrl #(
	parameter int CW = timer_evt_pkg::COUNT_W
) (
	input  wire logic                              mclk,          // 25 MHz peripheral clock
	input  wire logic                              rst_b,         // async reset, active low
	input  wire logic [timer_evt_pkg::ADDR_W-1:0]  regAddr,       // register address
	input  wire logic [timer_evt_pkg::DATA_W-1:0]  regWdata,      // write data
	input  wire logic                              regWr,         // write strobe
	input  wire logic                              regRd,         // read strobe
	output logic      [timer_evt_pkg::DATA_W-1:0]  regRdata,      // read data, cycle after strobe
	input  wire logic                              eventIn,       // routed event level
	input  wire logic [2:0]                        timerOperatingSelect, // mode code
	input  wire logic                              timerEnable,   // peripheral enabled
	input  wire logic                              cpuHalted,     // processor in break debug
	input  wire logic [CW-1:0]                     counterValue,  // live count
	input  wire logic [CW-1:0]                     compareSnapshotValue, // capture/compare value
	output logic                                   counterRun,    // counter may advance
	output logic                                   counterClear,  // pulse: count to bottom
	output logic                                   captureLoad,   // pulse: load capture value
	output logic      [CW-1:0]                     captureValue,  // count captured
	output logic                                   countWrite,    // pulse: commit count write
	output logic                                   snapWrite,     // pulse: commit compare write
	output logic      [CW-1:0]                     wideWriteData, // 16-bit data of commit
	output logic                                   irq            // interrupt request level
);
	logic [7:0]  eventInputR;
	logic [7:0]  irqEnableR;
	logic        snapFlagR;
	logic        bypassR;
	logic [7:0]  wideLatchR;
	logic        runFlagR;
	logic [7:0]  rdataR;
	logic        clearR;
	logic        loadR;
	logic [CW-1:0] captureR;
	logic        countWrR;
	logic        snapWrR;
	logic [CW-1:0] wideDataR;
	timer_evt_pkg::fp_state_t fpStateR;
	timer_evt_pkg::fp_state_t fpStateNxt;

	wire timer_evt_pkg::timer_mode_t mode = timer_evt_pkg::timer_mode_t'(timerOperatingSelect);

	// address decode
	wire wrEvt    = regWr && (regAddr == timer_evt_pkg::OFS_EVENT_INPUT);
	wire wrIen    = regWr && (regAddr == timer_evt_pkg::OFS_IRQ_ENABLE);
	wire wrFlag   = regWr && (regAddr == timer_evt_pkg::OFS_IRQ_FLAG);
	wire wrDbg    = regWr && (regAddr == timer_evt_pkg::OFS_DEBUG_HALT);
	wire wrLatch  = regWr && (regAddr == timer_evt_pkg::OFS_WIDE_LATCH);
	wire wrCtrLo  = regWr && (regAddr == timer_evt_pkg::OFS_COUNT_LO);
	wire wrCtrHi  = regWr && (regAddr == timer_evt_pkg::OFS_COUNT_HI);
	wire wrSnapLo = regWr && (regAddr == timer_evt_pkg::OFS_SNAP_LO);
	wire wrSnapHi = regWr && (regAddr == timer_evt_pkg::OFS_SNAP_HI);
	wire rdCtrLo  = regRd && (regAddr == timer_evt_pkg::OFS_COUNT_LO);
	wire rdSnapLo = regRd && (regAddr == timer_evt_pkg::OFS_SNAP_LO);

	// edge detection of the routed event
	logic evRise;
	logic evFall;
	edge_detect u_edge (
		.mclk  (mclk),
		.rst_b (rst_b),
		.level (eventIn),
		.rise  (evRise),
		.fall  (evFall)
	);

	wire halted   = cpuHalted && !bypassR;
	wire evEnable = eventInputR[timer_evt_pkg::BIT_EVENT_ENABLE] && !halted;
	wire edgeSel  = eventInputR[timer_evt_pkg::BIT_EDGE];
	// posSel: the edge that polarity 0 maps to rising; negSel the opposite one
	wire posSel   = evEnable && (edgeSel ? evFall : evRise);
	wire negSel   = evEnable && (edgeSel ? evRise : evFall);
	wire anySel   = evEnable && (evRise || evFall);

	wire isTimeout = (mode == timer_evt_pkg::MODE_TIMEOUT);
	wire isSingle  = (mode == timer_evt_pkg::MODE_SINGLE);
	wire isEvSnap  = (mode == timer_evt_pkg::MODE_CAPTURE);
	wire isFreq    = (mode == timer_evt_pkg::MODE_FREQ);
	wire isPulse   = (mode == timer_evt_pkg::MODE_PULSE);
	wire isFp      = (mode == timer_evt_pkg::MODE_FREQPULSE);
	wire isPwm     = (mode == timer_evt_pkg::MODE_PWM8);
	wire isTopMode = (mode == timer_evt_pkg::MODE_PERIODIC) || isTimeout || isSingle;
	wire isCaptureMode = isEvSnap || isFreq || isPulse || isFp;
	// modes that count freely once enabled; the others wait for a start
	wire freeRun   = !(isTimeout || isSingle || isFp);

	// event actions per mode; periodic and pwm8 have none
	wire fpFirst   = isFp && posSel && (fpStateR == timer_evt_pkg::FP_IDLE);
	wire fpGrab    = isFp && negSel && (fpStateR == timer_evt_pkg::FP_MEAS);
	wire fpStop    = isFp && posSel && (fpStateR == timer_evt_pkg::FP_WAIT);
	wire singleGo  = isSingle && (edgeSel ? anySel : evRise && evEnable);
	wire evStart   = (isTimeout && posSel) || singleGo || fpFirst;
	wire evStop    = (isTimeout && negSel) || fpStop;
	wire evCapture = (isEvSnap && posSel) || (isFreq && posSel)
		|| (isPulse && negSel) || fpGrab;
	wire evClear   = (isFreq && posSel) || (isPulse && posSel) || fpFirst;

	wire running   = timerEnable && !halted && (freeRun || runFlagR);
	wire topMatch  = running && isTopMode && (counterValue == compareSnapshotValue);
	wire pwmMatch  = running && isPwm
		&& (counterValue[7:0] == compareSnapshotValue[7:0]);
	wire singleEnd = running && isSingle && (counterValue == compareSnapshotValue);

	wire flagSet   = topMatch || pwmMatch || (isCaptureMode && !isFp && evCapture)
		|| fpStop;
	wire flagClr   = (wrFlag && regWdata[timer_evt_pkg::BIT_SNAP_FLAG])
		|| (rdSnapLo && isCaptureMode);

	always_comb begin
		fpStateNxt = fpStateR;
		case (fpStateR)
			timer_evt_pkg::FP_IDLE: begin
				if (fpFirst)
					fpStateNxt = timer_evt_pkg::FP_MEAS;
			end
			timer_evt_pkg::FP_MEAS: begin
				if (fpGrab)
					fpStateNxt = timer_evt_pkg::FP_WAIT;
			end
			timer_evt_pkg::FP_WAIT: begin
				if (fpStop)
					fpStateNxt = timer_evt_pkg::FP_IDLE;
			end
			default: fpStateNxt = timer_evt_pkg::FP_IDLE;
		endcase
		if (!isFp)
			fpStateNxt = timer_evt_pkg::FP_IDLE;
	end

	// read data selection
	logic [7:0] rdMux;
	always_comb begin
		rdMux = timer_evt_pkg::RST_BYTE;
		if (regAddr == timer_evt_pkg::OFS_EVENT_INPUT)
			rdMux = eventInputR;
		else if (regAddr == timer_evt_pkg::OFS_IRQ_ENABLE)
			rdMux = irqEnableR;
		else if (regAddr == timer_evt_pkg::OFS_IRQ_FLAG)
			rdMux = {7'h00, snapFlagR};
		else if (regAddr == timer_evt_pkg::OFS_RUN_STATE)
			rdMux = {7'h00, running};
		else if (regAddr == timer_evt_pkg::OFS_DEBUG_HALT)
			rdMux = {7'h00, bypassR};
		else if (regAddr == timer_evt_pkg::OFS_WIDE_LATCH)
			rdMux = wideLatchR;
		else if (regAddr == timer_evt_pkg::OFS_COUNT_LO)
			rdMux = counterValue[7:0];
		else if (regAddr == timer_evt_pkg::OFS_SNAP_LO)
			rdMux = compareSnapshotValue[7:0];
		else if (regAddr == timer_evt_pkg::OFS_COUNT_HI || regAddr == timer_evt_pkg::OFS_SNAP_HI)
			rdMux = wideLatchR;
	end

	// software control registers
	always_ff @(posedge mclk or negedge rst_b) begin
		if (!rst_b) begin
			eventInputR <= timer_evt_pkg::RST_BYTE;
			irqEnableR  <= timer_evt_pkg::RST_BYTE;
			bypassR     <= 1'b0;
		end else begin
			if (wrEvt)
				eventInputR <= regWdata & timer_evt_pkg::EVT_MASK;
			if (wrIen)
				irqEnableR <= regWdata & timer_evt_pkg::BIT0_MASK;
			if (wrDbg)
				bypassR <= regWdata[timer_evt_pkg::BIT_BYPASS];
		end
	end

	// shared latch: low read grabs high byte, low write parks data
	always_ff @(posedge mclk or negedge rst_b) begin
		if (!rst_b)
			wideLatchR <= timer_evt_pkg::RST_BYTE;
		else if (rdCtrLo)
			wideLatchR <= counterValue[15:8];
		else if (rdSnapLo)
			wideLatchR <= compareSnapshotValue[15:8];
		else if (wrLatch || wrCtrLo || wrSnapLo)
			wideLatchR <= regWdata;
	end

	// high write commits both bytes in one cycle
	always_ff @(posedge mclk or negedge rst_b) begin
		if (!rst_b) begin
			countWrR  <= 1'b0;
			snapWrR   <= 1'b0;
			wideDataR <= '0;
		end else begin
			countWrR <= wrCtrHi;
			snapWrR  <= wrSnapHi;
			if (wrCtrHi || wrSnapHi)
				wideDataR <= {regWdata, wideLatchR};
		end
	end

	// flag: a set in the same cycle as a clear wins
	always_ff @(posedge mclk or negedge rst_b) begin
		if (!rst_b)
			snapFlagR <= 1'b0;
		else if (flagSet)
			snapFlagR <= 1'b1;
		else if (flagClr)
			snapFlagR <= 1'b0;
	end

	// start/stop state for modes that wait for an event
	always_ff @(posedge mclk or negedge rst_b) begin
		if (!rst_b)
			runFlagR <= 1'b0;
		else if (!timerEnable || freeRun)
			runFlagR <= 1'b0;
		else if (evStart)
			runFlagR <= 1'b1;
		else if (evStop || singleEnd)
			runFlagR <= 1'b0;
	end

	always_ff @(posedge mclk or negedge rst_b) begin
		if (!rst_b)
			fpStateR <= timer_evt_pkg::FP_IDLE;
		else
			fpStateR <= fpStateNxt;
	end

	// capture and restart pulses toward the counter
	always_ff @(posedge mclk or negedge rst_b) begin
		if (!rst_b) begin
			clearR   <= 1'b0;
			loadR    <= 1'b0;
			captureR <= '0;
		end else begin
			clearR <= evClear;
			loadR  <= evCapture;
			if (evCapture)
				captureR <= counterValue;
		end
	end

	// read data stands for one cycle only
	always_ff @(posedge mclk or negedge rst_b) begin
		if (!rst_b)
			rdataR <= timer_evt_pkg::RST_BYTE;
		else if (regRd)
			rdataR <= rdMux;
		else
			rdataR <= timer_evt_pkg::RST_BYTE;
	end

	assign regRdata      = rdataR;
	assign counterRun    = running;
	assign counterClear  = clearR;
	assign captureLoad   = loadR;
	assign captureValue  = captureR;
	assign countWrite    = countWrR;
	assign snapWrite     = snapWrR;
	assign wideWriteData = wideDataR;
	assign irq           = snapFlagR && irqEnableR[0];
endmodule
`default_nettype wire

// ===== test/timer_evt_checker_assertions.sv
// port assertions for the timer event capture block
`timescale 1ns/100ps
`default_nettype none
module timer_evt_checker #(
	parameter int CW = 16
) (
	input wire logic          mclk,                 // clock
	input wire logic          rst_b,                // reset, active low
	input wire logic [3:0]    regAddr,              // address
	input wire logic [7:0]    regWdata,             // write data
	input wire logic          regWr,                // write strobe
	input wire logic          regRd,                // read strobe
	input wire logic [7:0]    regRdata,             // read data
	input wire logic [2:0]    timerOperatingSelect, // mode
	input wire logic          cpuHalted,            // break debug
	input wire logic [CW-1:0] counterValue,         // count
	input wire logic          counterRun,           // run
	input wire logic          counterClear,         // clear pulse
	input wire logic          captureLoad,          // load pulse
	input wire logic [CW-1:0] captureValue,         // snapshot
	input wire logic          countWrite,           // count commit
	input wire logic          snapWrite,            // compare commit
	input wire logic [CW-1:0] wideWriteData,        // commit data
	input wire logic          irq                   // interrupt
);
	logic      bypass_r;
	logic      evEn_r;
	logic      irqEn_r;
	wire logic wrLo  = regWr && (regAddr == 4'hc);
	wire logic wrHi  = regWr && (regAddr == 4'hd);
	wire logic wrCtr = regWr && (regAddr == 4'hb);
	wire logic rdRun = regRd && (regAddr == 4'h7) && !cpuHalted;
	wire logic idle  = timerOperatingSelect inside {3'h0, 3'h7};
	wire logic clrMd = timerOperatingSelect inside {3'h3, 3'h4, 3'h5};
	// enable bits are internal, so shadow them from the bus
	always_ff @(posedge mclk or negedge rst_b) begin
		if (!rst_b) begin
			bypass_r <= 1'b0;
			evEn_r <= 1'b0;
			irqEn_r <= 1'b0;
		end else if (regWr) begin
			if (regAddr == 4'h8) bypass_r <= regWdata[0];
			if (regAddr == 4'h4) evEn_r <= regWdata[0];
			if (regAddr == 4'h5) irqEn_r <= regWdata[0];
		end
	end
	default clocking cb @(posedge mclk); endclocking
	default disable iff (!rst_b);
	idle_modes_a: assert property (idle && $stable(timerOperatingSelect) |-> !captureLoad)
		else $error("capture in a mode that ignores events");
	capture_keep_a: assert property (captureLoad && timerOperatingSelect == 3'h2
		&& $stable(timerOperatingSelect) |-> !counterClear) else $error("capture mode cleared");
	freq_restart_a: assert property (captureLoad && timerOperatingSelect == 3'h3
		&& $stable(timerOperatingSelect) |-> counterClear) else $error("frequency no restart");
	snap_value_a: assert property (captureLoad |-> captureValue == $past(counterValue))
		else $error("captured value wrong");
	event_gate_a: assert property (!evEn_r && !$past(evEn_r) |-> !captureLoad
		&& !(counterClear && clrMd)) else $error("event acted while disabled");
	irq_enable_a: assert property (irq |-> irqEn_r)
		else $error("interrupt while disabled");
	run_read_a: assert property ($past(rdRun) |-> regRdata == {7'h00, $past(counterRun)})
		else $error("run bit read wrong");
	halt_stop_a: assert property (cpuHalted && !bypass_r |-> !counterRun)
		else $error("counter runs in break debug");
	wide_write_a: assert property ($past(wrHi) && $past(wrLo, 2) |-> snapWrite
		&& wideWriteData == {$past(regWdata), $past(regWdata, 2)}) else $error("wide write bad");
	count_write_a: assert property ($past(wrCtr) |=> !countWrite)
		else $error("count commit too long");
endmodule
bind timer_event_capture_ctrl timer_evt_checker #(.CW(CW)) i_timer_evt_checker (.mclk, .rst_b,
	.regAddr, .regWdata, .regWr, .regRd, .regRdata, .timerOperatingSelect, .cpuHalted,
	.counterValue, .counterRun, .counterClear, .captureLoad, .captureValue, .countWrite,
	.snapWrite, .wideWriteData, .irq);
`default_nettype wire

// ===== test/timer_counter_model.sv
// behavioural counter and compare register beside the block
`timescale 1ns/100ps
`default_nettype none
module timer_counter_model #(
	parameter int CW = 16
) (
	input  wire logic          mclk,                 // clock
	input  wire logic          rst_b,                // reset, active low
	input  wire logic          counterRun,           // advance
	input  wire logic          counterClear,         // to bottom
	input  wire logic          captureLoad,          // snapshot load
	input  wire logic [CW-1:0] captureValue,         // snapshot
	input  wire logic          countWrite,           // count commit
	input  wire logic          snapWrite,            // compare commit
	input  wire logic [CW-1:0] wideWriteData,        // commit data
	output logic      [CW-1:0] counterValue,         // live count
	output logic      [CW-1:0] compareSnapshotValue  // compare value
);
	// software writes win over internal updates
	always_ff @(posedge mclk or negedge rst_b) begin
		if (!rst_b) begin
			counterValue <= '0;
			compareSnapshotValue <= '0;
		end else begin
			if (countWrite) counterValue <= wideWriteData;
			else if (counterClear) counterValue <= '0;
			else if (counterRun) counterValue <= counterValue + CW'(1);
			if (snapWrite) compareSnapshotValue <= wideWriteData;
			else if (captureLoad) compareSnapshotValue <= captureValue;
		end
	end
endmodule
`default_nettype wire

// ===== test/testbench.sv
// self-checking bench for the timer event capture block
`timescale 1ns/100ps
`default_nettype none
module testbench;
	logic        mclk, rst_b, regWr, regRd, eventIn, timerEnable, cpuHalted;
	logic [3:0]  regAddr;
	logic [7:0]  regWdata, regRdata;
	logic [2:0]  timerOperatingSelect;
	logic [15:0] counterValue, compareSnapshotValue, captureValue, wideWriteData;
	logic        counterRun, counterClear, captureLoad, countWrite, snapWrite, irq;
	int          failures = 0, num_checks = 0, nLoad = 0, nClr = 0;
	timer_event_capture_ctrl i_timer_event_capture_ctrl (.mclk, .rst_b, .regAddr, .regWdata,
		.regWr, .regRd, .regRdata, .eventIn, .timerOperatingSelect, .timerEnable, .cpuHalted,
		.counterValue, .compareSnapshotValue, .counterRun, .counterClear, .captureLoad,
		.captureValue, .countWrite, .snapWrite, .wideWriteData, .irq);
	timer_counter_model i_timer_counter_model (.mclk, .rst_b, .counterRun, .counterClear,
		.captureLoad, .captureValue, .countWrite, .snapWrite, .wideWriteData, .counterValue,
		.compareSnapshotValue);
	initial begin
		mclk = 1'b0;
		forever #20 mclk = ~mclk;
	end
	always @(posedge mclk) begin
		nLoad <= nLoad + int'(captureLoad === 1'b1);
		nClr <= nClr + int'(counterClear === 1'b1);
	end
	task automatic print_verdict();
		if (failures == 0 && num_checks > 0) $display("verification passed");
		else $display("verification failed");
		$finish;
	endtask
	task automatic chk(input logic [15:0] got, input logic [15:0] exp);
		num_checks++;
		if (got !== exp) begin
			failures++;
			$display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask
	task automatic wr(input logic [3:0] a, input logic [7:0] d);
		@(posedge mclk);
		regWr <= 1'b1;
		regAddr <= a;
		regWdata <= d;
		@(posedge mclk);
		regWr <= 1'b0;
	endtask
	// low then high byte with no gap, so the commit pairs the high byte with the low byte parked in the latch
	task automatic wr16(input logic [3:0] a, input logic [15:0] d);
		@(posedge mclk);
		regWr <= 1'b1;
		regAddr <= a;
		regWdata <= d[7:0];
		@(posedge mclk);
		regAddr <= a + 4'h1;
		regWdata <= d[15:8];
		@(posedge mclk);
		regWr <= 1'b0;
	endtask
	task automatic rd(input logic [3:0] a, input logic [7:0] exp);
		@(posedge mclk);
		regRd <= 1'b1;
		regAddr <= a;
		@(posedge mclk);
		regRd <= 1'b0;
		#1 chk(16'(regRdata), 16'(exp));
	endtask
	// three edges: detect, act, flag settles
	task automatic evt(input logic lvl);
		@(posedge mclk);
		eventIn <= lvl;
		repeat (3) @(posedge mclk);
	endtask
	task automatic edge_step(input logic lvl, input int dc, input int dl);
		int c0 = nClr;
		int l0 = nLoad;
		evt(lvl);
		chk(16'(nClr - c0), 16'(dc));
		chk(16'(nLoad - l0), 16'(dl));
	endtask
	// level is moved while events are off, so no edge leaks into the new mode
	task automatic arm(input logic [2:0] m, input logic pol);
		wr(4'h4, 8'h00);
		eventIn <= pol;
		timerOperatingSelect <= m;
		wr(4'h4, {3'h0, pol, 4'h1});
	endtask
	task automatic t_regs();
		logic [3:0] adr [6] = '{4'h5, 4'h6, 4'h7, 4'h8, 4'h9, 4'he};
		wr(4'he, 8'h5a);
		foreach (adr[i]) rd(adr[i], 8'h00);
	endtask
	task automatic t_latch();
		wr(4'h9, 8'h5a);
		rd(4'h9, 8'h5a);
		wr16(4'hc, 16'h1234);
		rd(4'hc, 8'h34);
		rd(4'hd, 8'h12);
	endtask
	task automatic t_compare();
		@(posedge mclk);
		timerEnable <= 1'b1;
		wr16(4'hc, 16'h0020);
		wr16(4'ha, 16'h0000);
		repeat (40) @(posedge mclk);
		rd(4'h6, 8'h01);
		chk(16'(irq), 16'h0);
		@(posedge mclk);
		timerOperatingSelect <= 3'h2;
		wr(4'h6, 8'h00);
		rd(4'h6, 8'h01);
		wr(4'h6, 8'h01);
		rd(4'h6, 8'h00);
		@(posedge mclk);
		timerOperatingSelect <= 3'h7;
		wr16(4'hc, 16'hff10);
		wr16(4'ha, 16'h0000);
		repeat (20) @(posedge mclk);
		rd(4'h6, 8'h01);
		@(posedge mclk);
		timerOperatingSelect <= 3'h2;
		wr(4'h6, 8'h01);
	endtask
	task automatic t_halt();
		cpuHalted <= 1'b1;
		@(posedge mclk);
		#1 chk(16'(counterRun), 16'h0);
		arm(3'h2, 1'b0);
		edge_step(1'b1, 0, 0);
		wr(4'h8, 8'h01);
		rd(4'h8, 8'h01);
		chk(16'(counterRun), 16'h1);
		wr(4'h8, 8'h00);
		cpuHalted <= 1'b0;
	endtask
	task automatic t_capture();
		wr(4'h5, 8'h01);
		for (int p = 0; p < 2; p++) begin
			arm(3'h2, p[0]);
			edge_step(!p[0], 0, 1);
			edge_step(p[0], 0, 0);
			chk(16'(irq), 16'h1);
			rd(4'hc, compareSnapshotValue[7:0]);
			rd(4'h6, 8'h00);
		end
		wr(4'h4, 8'h00);
		edge_step(1'b0, 0, 0);
		edge_step(1'b1, 0, 0);
	endtask
	task automatic t_meas();
		arm(3'h3, 1'b1);
		edge_step(1'b0, 1, 1);
		edge_step(1'b1, 0, 0);
		arm(3'h4, 1'b0);
		edge_step(1'b1, 1, 0);
		edge_step(1'b0, 0, 1);
		arm(3'h5, 1'b0);
		wr(4'h6, 8'h01);
		edge_step(1'b1, 1, 0);
		edge_step(1'b0, 0, 1);
		rd(4'h6, 8'h00);
		edge_step(1'b1, 0, 0);
		rd(4'h6, 8'h01);
		chk(16'(counterRun), 16'h0);
	endtask
	task automatic t_start();
		wr(4'h5, 8'h00);
		wr16(4'hc, 16'hffff);
		wr16(4'ha, 16'h0000);
		arm(3'h0, 1'b0);
		edge_step(1'b1, 0, 0);
		arm(3'h7, 1'b0);
		edge_step(1'b1, 0, 0);
		arm(3'h1, 1'b0);
		rd(4'h7, 8'h00);
		wr(4'h7, 8'h01);
		rd(4'h7, 8'h00);
		evt(1'b1);
		rd(4'h7, 8'h01);
		evt(1'b0);
		rd(4'h7, 8'h00);
		arm(3'h6, 1'b1);
		rd(4'h7, 8'h00);
		evt(1'b0);
		rd(4'h7, 8'h01);
	endtask
	initial begin
		rst_b = 1'b0;
		regAddr = 4'h0;
		regWdata = 8'h00;
		regWr = 1'b0;
		regRd = 1'b0;
		eventIn = 1'b0;
		timerOperatingSelect = 3'h0;
		timerEnable = 1'b0;
		cpuHalted = 1'b0;
		repeat (4) @(posedge mclk);
		rst_b <= 1'b1;
		t_regs();
		t_latch();
		t_compare();
		t_halt();
		t_capture();
		t_meas();
		t_start();
		print_verdict();
	end
	initial begin
		repeat (20000) @(posedge mclk);
		failures++;
		print_verdict();
	end
endmodule
`default_nettype wire
